// ===== rtl/brom_edge_sync.sv
`timescale 1ns/1ns
module brom_edge_sync
(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic nrst,
    // Pin side
    input  wire logic pin_n,
    // Rising edge of the synchronised pin
    output logic      rise
);
    import brom_pkg::*;

    typedef struct packed
    {
        logic [1:0] sync;
        logic       last;
    } brom_sync_t;

    brom_sync_t s_q;
    brom_sync_t s_d;

    always_comb
    begin
        s_d      = s_q;
        s_d.sync = {s_q.sync[0], pin_n};
        s_d.last = s_q.sync[1];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            s_q <= {SYNC_RESET, 1'h1};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Strobe released: low to high
    assign rise = s_q.sync[1] & ~s_q.last;
endmodule // brom_edge_sync

// ===== rtl/brom_overlay_map.sv
`timescale 1ns/1ns
module brom_overlay_map
(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic nrst,
    // Processor bus and jumper pins
    input  wire logic address_strobe_n,
    input  wire logic overlay_force_jumper,
    // Stage outputs
    output logic      first_stage_out,
    output logic      fourth_stage_out,
    // Overlay to the address decoder
    output logic      overlay_n
);
    import brom_pkg::*;

    typedef struct packed
    {
        logic [STAGES-1:0] shift;
        logic [1:0]        jsync;
        logic              ovl_n;
    } brom_state_t;

    brom_state_t st_q;
    brom_state_t st_d;
    logic        strobe_done;

    // One strobe step: a one enters stage one, the rest move up
    function automatic logic [STAGES-1:0] shift_step
    (
        input logic [STAGES-1:0] cur
    );
        shift_step = {cur[STAGES-2:0], SERIAL_IN};
    endfunction

    // True when the set stages form an unbroken run from stage one
    function automatic logic filled_from_first
    (
        input logic [STAGES-1:0] stages
    );
        filled_from_first = ((stages + STAGES'(1)) & stages) == STAGES'(0);
    endfunction

    brom_edge_sync u_as_sync
    (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .pin_n   (address_strobe_n),
        .rise    (strobe_done)
    );

    always_comb
    begin
        st_d       = st_q;
        st_d.jsync = {st_q.jsync[0], overlay_force_jumper};
        if (strobe_done)
        begin
            st_d.shift = shift_step(st_q.shift);
        end
        // Low keeps ROM at zero; high hands zero to RAM
        st_d.ovl_n = st_d.shift[TAP_STAGE] & ~st_q.jsync[1];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            st_q <= {SHIFT_RESET, 2'h0, 1'h0};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign first_stage_out  = st_q.shift[0];
    assign fourth_stage_out = st_q.shift[TAP_STAGE];
    assign overlay_n        = st_q.ovl_n;

    // Helper: strobes since reset, saturating
    logic [3:0] n_strobes_q;
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            n_strobes_q <= 4'h0;
        end
        else if (strobe_done && n_strobes_q != 4'hF)
        begin
            n_strobes_q <= n_strobes_q + 4'h1;
        end
    end

    a_reset_clears: assert property
    (
        @(posedge clk_sys)
        !nrst |=> st_q.shift == SHIFT_RESET
    )
    else
    begin
        $error("reset did not clear the shift register");
    end

    a_reset_outputs_low: assert property
    (
        @(posedge clk_sys)
        !nrst |=> !overlay_n && !first_stage_out && !fourth_stage_out
    )
    else
    begin
        $error("outputs not low after reset");
    end

    a_overlay_low_clear: assert property
    (
        @(posedge clk_sys) disable iff (!nrst)
        !fourth_stage_out |-> !overlay_n
    )
    else
    begin
        $error("overlay high while tap stage clear");
    end

    a_shift_on_edge: assert property
    (
        @(posedge clk_sys) disable iff (!nrst)
        strobe_done |=> st_q.shift == {$past(st_q.shift[STAGES-2:0]), 1'b1}
    )
    else
    begin
        $error("register did not shift on strobe");
    end

    a_hold_no_edge: assert property
    (
        @(posedge clk_sys) disable iff (!nrst)
        !strobe_done |=> $stable(st_q.shift)
    )
    else
    begin
        $error("register moved without strobe");
    end

    a_first_stage_one: assert property
    (
        @(posedge clk_sys) disable iff (!nrst)
        strobe_done |=> first_stage_out
    )
    else
    begin
        $error("first stage did not take a one");
    end

    a_stages_filled: assert property
    (
        @(posedge clk_sys) disable iff (!nrst)
        filled_from_first(st_q.shift)
    )
    else
    begin
        $error("set stages not a run from stage one");
    end

    a_tap_after_four: assert property
    (
        @(posedge clk_sys) disable iff (!nrst)
        fourth_stage_out == (n_strobes_q >= 4'h4)
    )
    else
    begin
        $error("tap stage not tied to four strobes");
    end

    a_overlay_needs_tap: assert property
    (
        @(posedge clk_sys) disable iff (!nrst)
        overlay_n |-> fourth_stage_out
    )
    else
    begin
        $error("overlay high before four strobes");
    end

    a_overlay_release: assert property
    (
        @(posedge clk_sys) disable iff (!nrst)
        fourth_stage_out && !st_q.jsync[1] |-> ##[0:1] overlay_n
    )
    else
    begin
        $error("overlay did not release ROM");
    end

    a_force_low: assert property
    (
        @(posedge clk_sys) disable iff (!nrst)
        st_q.jsync[1] |=> !overlay_n
    )
    else
    begin
        $error("forced overlay not low");
    end

    a_stays_high: assert property
    (
        @(posedge clk_sys) disable iff (!nrst)
        fourth_stage_out && !st_q.jsync[1] ##1 !st_q.jsync[1] |-> overlay_n
    )
    else
    begin
        $error("overlay fell before reset");
    end

    a_no_stage_lost: assert property
    (
        @(posedge clk_sys) disable iff (!nrst)
        ($past(st_q.shift) & ~st_q.shift) == STAGES'(0)
    )
    else
    begin
        $error("a set stage cleared without reset");
    end

    c_four_strobes: cover property
    (
        @(posedge clk_sys) disable iff (!nrst) $rose(overlay_n)
    );

    c_forced: cover property
    (
        @(posedge clk_sys) disable iff (!nrst) fourth_stage_out && !overlay_n
    );

    c_full: cover property
    (
        @(posedge clk_sys) disable iff (!nrst) st_q.shift[STAGES-1]
    );

    c_jumper_release: cover property
    (
        @(posedge clk_sys) disable iff (!nrst) $fell(st_q.jsync[1]) && fourth_stage_out
    );

    c_first_strobe: cover property
    (
        @(posedge clk_sys) disable iff (!nrst) strobe_done && !first_stage_out
    );
endmodule // brom_overlay_map

// ===== rtl/brom_pkg.sv
package brom_pkg;
    localparam int         STAGES       = 8;
    localparam int         TAP_STAGE    = 3;
    localparam logic [7:0] SHIFT_RESET  = 8'h00;
    localparam logic       SERIAL_IN    = 1'h1;
    localparam logic [1:0] SYNC_RESET   = 2'h3;
endpackage

// ===== tb/brom_bus_model.sv
`timescale 1ns/1ns
module brom_bus_model
(
    // Clock and overlay from the block
    input  wire logic clk_sys,
    input  wire logic overlay_n,
    // Strobe and decoder selects
    output logic      address_strobe_n,
    output logic      dram_select_n,
    output logic      other_region_select_n
);
    int seed = 32'h12E4BB68;
    initial address_strobe_n = 1'h1;
    assign dram_select_n         = ~overlay_n;
    assign other_region_select_n = overlay_n;
    // One strobe per 16-bit read, random widths
    task automatic reads(input int n);
        repeat (n)
        begin
            @(negedge clk_sys) address_strobe_n = 1'h0;
            repeat (2 + $unsigned($random(seed)) % 4) @(negedge clk_sys);
            address_strobe_n = 1'h1;
            repeat (3 + $unsigned($random(seed)) % 4) @(negedge clk_sys);
        end
    endtask
endmodule // brom_bus_model

// ===== tb/brom_overlay_map_tb.sv
`timescale 1ns/1ns
module brom_overlay_map_tb;
    import brom_pkg::*;
    logic clk_sys = 1'h0;
    logic nrst    = 1'h0;
    logic jumper  = 1'h0;
    logic strobe_n, first_q, fourth_q, ovl_n, dram_n, other_n;
    int   failures    = 0;
    int   comparisons = 0;
    initial forever #5 clk_sys = ~clk_sys;
    brom_overlay_map brom_overlay_map_i (.clk_sys(clk_sys), .nrst(nrst), .address_strobe_n(strobe_n),
        .overlay_force_jumper(jumper), .first_stage_out(first_q), .fourth_stage_out(fourth_q), .overlay_n(ovl_n));
    brom_bus_model brom_bus_model_i (.clk_sys(clk_sys), .overlay_n(ovl_n), .address_strobe_n(strobe_n),
        .dram_select_n(dram_n), .other_region_select_n(other_n));
    task automatic check(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask
    // Levels the rules give after n strobes since reset
    function automatic logic exp_stage(input int n, input int stage);
        return n > stage;
    endfunction
    function automatic logic exp_overlay(input int n, input logic force_low);
        return exp_stage(n, TAP_STAGE) && !force_low;
    endfunction
    // Outputs expected after n strobes since reset
    task automatic expect_all(input int n);
        repeat (3) @(negedge clk_sys);
        check("first_stage_out", exp_stage(n, 0), first_q);
        check("fourth_stage_out", exp_stage(n, TAP_STAGE), fourth_q);
        check("overlay_n", exp_overlay(n, jumper), ovl_n);
        check("dram_select_n", !exp_overlay(n, jumper), dram_n);
        check("other_region_select_n", exp_overlay(n, jumper), other_n);
        $display("test after %0d strobes done", n);
    endtask
    task automatic stop_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #20000;
        failures++;
        stop_test();
    end
    initial
    begin
        repeat (5) @(negedge clk_sys);
        nrst = 1'h1;
        expect_all(0);
        for (int n = 1; n <= 6; n++)
        begin
            brom_bus_model_i.reads(1);
            expect_all(n);
        end
        jumper = 1'h1;
        expect_all(6);
        jumper = 1'h0;
        expect_all(6);
        nrst = 1'h0;
        repeat (5) @(negedge clk_sys);
        nrst = 1'h1;
        expect_all(0);
        jumper = 1'h1;
        brom_bus_model_i.reads(4);
        expect_all(4);
        jumper = 1'h0;
        expect_all(4);
        brom_bus_model_i.reads(5);
        expect_all(9);
        stop_test();
    end
endmodule // brom_overlay_map_tb
